// >>> cpg_pkg.sv
package cpg_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] CPG_OFS_RC80_CTRL   = 12'h3c0;
	localparam logic [11:0] CPG_OFS_HRP_CTRL    = 12'h3c4;
	localparam logic [11:0] CPG_OFS_FP_CTRL     = 12'h3c8;
	localparam logic [11:0] CPG_OFS_FP_MUL      = 12'h3cc;
	localparam logic [11:0] CPG_OFS_FP_DIV      = 12'h3d0;
	localparam logic [11:0] CPG_OFS_GC_BASE     = 12'h3a0;
	localparam logic [11:0] CPG_OFS_FRC_VERSION = 12'h3d8;
	localparam logic [11:0] CPG_OFS_PRE_VERSION = 12'h3dc;

	// ----------------------------------------------------------------
	// sizes and field positions
	// ----------------------------------------------------------------
	localparam int          CPG_NUM_GC       = 4;
	localparam int          CPG_NUM_SRC      = 8;
	localparam int          CPG_HRP_LSB      = 8;
	localparam int          CPG_SEL_LSB      = 1;
	localparam int          CPG_GC_SEL_LSB   = 8;
	localparam int          CPG_GC_DIV_LSB   = 16;
	localparam int          CPG_RC80_TRIM_LSB = 16;
	localparam int          CPG_RC80_FCD_BIT = 7;
	localparam logic [31:0] CPG_RESET_VALUE  = 32'h0000_0000;
	localparam logic [1:0]  CPG_RESP_OKAY    = 2'b00;
	localparam logic [1:0]  CPG_RESP_SLVERR  = 2'b10;

	// identification values: arbitrary, carry no meaning
	localparam logic [11:0] CPG_FRC_VERSION_NUM = 12'h101;
	localparam logic [11:0] CPG_PRE_VERSION_NUM = 12'h102;
	localparam logic [3:0]  CPG_VARIANT_NUM     = 4'h0;
	localparam int          CPG_VARIANT_LSB     = 16;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] sel;
		logic       on;
	} cpg_pre_ctrl_t;

	typedef struct packed {
		logic [15:0] div;
		logic [4:0]  sel;
		logic        divide_on;
		logic        on;
	} cpg_gc_ctrl_t;

	typedef enum logic [1:0] {
		CPG_BUS_IDLE = 2'b00,
		CPG_BUS_RESP = 2'b01
	} cpg_bus_state_t;

endpackage

// >>> cpg_top.sv
`timescale 1ns/1ps
module cpg_top
	import cpg_pkg::*;
(
	input  wire logic                   clk,                // 200 MHz system clock
	input  wire logic                   srst,               // sync reset, active high
	input  wire logic [CPG_NUM_SRC-1:0] src_tick,           // source clock enables, one cycle each
	input  wire logic [9:0]             trim_fuse,          // trim from fuses
	input  wire logic                   trim_fuse_valid,    // fuse trim ready to load
	input  wire logic [11:0]            s_axi_awaddr,       // write address
	input  wire logic                   s_axi_awvalid,      // write address valid
	output logic                        s_axi_awready,      // write address ready
	input  wire logic [31:0]            s_axi_wdata,        // write data
	input  wire logic [3:0]             s_axi_wstrb,        // write byte enables
	input  wire logic                   s_axi_wvalid,       // write data valid
	output logic                        s_axi_wready,       // write data ready
	output logic [1:0]                  s_axi_bresp,        // write response
	output logic                        s_axi_bvalid,       // write response valid
	input  wire logic                   s_axi_bready,       // write response ready
	input  wire logic [11:0]            s_axi_araddr,       // read address
	input  wire logic                   s_axi_arvalid,      // read address valid
	output logic                        s_axi_arready,      // read address ready
	output logic [31:0]                 s_axi_rdata,        // read data
	output logic [1:0]                  s_axi_rresp,        // read response
	output logic                        s_axi_rvalid,       // read data valid
	input  wire logic                   s_axi_rready,       // read data ready
	output logic                        rc80_run,           // rc80 oscillator enable
	output logic                        hires_prescaled_clock, // hires prescaler clock
	output logic                        frac_prescaled_clock,  // fractional prescaler clock
	output logic [CPG_NUM_GC-1:0]       gen_clock           // generic clocks
);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic                 rc80_on;
	logic [9:0]           trim_value;
	logic                 fuse_trim_loaded;
	logic [23:0]          hires_period_count;
	cpg_pre_ctrl_t        hires_ctrl;
	cpg_pre_ctrl_t        frac_ctrl;
	logic [15:0]          frac_multiplier;
	logic [15:0]          frac_divisor;
	cpg_gc_ctrl_t         gc_ctrl [CPG_NUM_GC];

	// ----------------------------------------------------------------
	// write channel: address and data taken in either order
	// ----------------------------------------------------------------
	logic        aw_held;
	logic        w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	wire         aw_take   = s_axi_awvalid & s_axi_awready;
	wire         w_take    = s_axi_wvalid & s_axi_wready;
	wire         have_aw   = aw_held | aw_take;
	wire         have_w    = w_held | w_take;
	wire         wr_do     = have_aw & have_w & ~s_axi_bvalid;
	wire [11:0]  wr_addr   = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0]  wr_data   = w_held ? w_data : s_axi_wdata;
	wire [3:0]   wr_strb   = w_held ? w_strb : s_axi_wstrb;
	wire [31:0]  wr_mask   = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

	// write address decode
	// version words decode as mapped: writes get okay and are dropped
	wire         wr_rc80   = wr_addr == CPG_OFS_RC80_CTRL;
	wire         wr_hrp    = wr_addr == CPG_OFS_HRP_CTRL;
	wire         wr_fpc    = wr_addr == CPG_OFS_FP_CTRL;
	wire         wr_fpm    = wr_addr == CPG_OFS_FP_MUL;
	wire         wr_fpd    = wr_addr == CPG_OFS_FP_DIV;
	wire         wr_gc_hit = wr_addr[11:4] == CPG_OFS_GC_BASE[11:4];
	wire [1:0]   wr_gc_idx = wr_addr[3:2];
	wire         wr_ro     = (wr_addr == CPG_OFS_FRC_VERSION) | (wr_addr == CPG_OFS_PRE_VERSION);
	wire         wr_ok     = wr_rc80 | wr_hrp | wr_fpc | wr_fpm | wr_fpd | wr_gc_hit | wr_ro;

	// merge helper: keep bytes whose strobe is low
	// read-only bits are rebuilt from state, so a merge cannot disturb them
	function automatic logic [31:0] cpg_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [31:0] mask);
		cpg_merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	wire [31:0]  cur_rc80  = (32'(trim_value) << CPG_RC80_TRIM_LSB) | (32'(fuse_trim_loaded) << CPG_RC80_FCD_BIT)
		| 32'(rc80_on);
	wire [31:0]  cur_hrp   = {hires_period_count, 4'h0, hires_ctrl.sel, hires_ctrl.on};
	wire [31:0]  cur_fpc   = {28'h0, frac_ctrl.sel, frac_ctrl.on};
	wire [31:0]  new_rc80  = cpg_merge(cur_rc80, wr_data, wr_mask);
	wire [31:0]  new_hrp   = cpg_merge(cur_hrp, wr_data, wr_mask);
	wire [31:0]  new_fpc   = cpg_merge(cur_fpc, wr_data, wr_mask);
	wire [31:0]  new_fpm   = cpg_merge({16'h0, frac_multiplier}, wr_data, wr_mask);
	wire [31:0]  new_fpd   = cpg_merge({16'h0, frac_divisor}, wr_data, wr_mask);
	wire [31:0]  cur_gcw   = {gc_ctrl[wr_gc_idx].div, 3'h0, gc_ctrl[wr_gc_idx].sel, 6'h00,
		gc_ctrl[wr_gc_idx].divide_on, gc_ctrl[wr_gc_idx].on};
	wire [31:0]  new_gc    = cpg_merge(cur_gcw, wr_data, wr_mask);

	// one write in flight: a new pair waits until bready takes the answer
	// write handshake and response
	always_ff @(posedge clk) begin
		if (srst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= CPG_RESET_VALUE;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CPG_RESP_OKAY;
		end else begin
			if (aw_take & ~wr_do) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_do) begin
				aw_held <= 1'b0;
			end
			if (w_take & ~wr_do) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_do) begin
				w_held <= 1'b0;
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? CPG_RESP_OKAY : CPG_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ready while nothing of that channel is held and no response pending
	// registered readies cost a cycle but keep the bus free of long paths
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= ~(have_aw & ~wr_do) & ~(s_axi_bvalid & ~s_axi_bready) & ~wr_do;
			s_axi_wready <= ~(have_w & ~wr_do) & ~(s_axi_bvalid & ~s_axi_bready) & ~wr_do;
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// trim loads once per reset; later fuse strobes are ignored
	// trim from fuses only: bus writes never reach trim_value
	always_ff @(posedge clk) begin
		if (srst) begin
			trim_value <= 10'h000;
			fuse_trim_loaded <= 1'b0;
		end else if (trim_fuse_valid & ~fuse_trim_loaded) begin
			trim_value <= trim_fuse;
			fuse_trim_loaded <= 1'b1;
		end
	end

	// new counts take effect at the next compare, with no restart
	// enable bit; values change while running
	always_ff @(posedge clk) begin
		if (srst) begin
			rc80_on <= 1'b0;
			hires_ctrl <= '0;
			hires_period_count <= 24'h000000;
			frac_ctrl <= '0;
			frac_multiplier <= 16'h0000;
			frac_divisor <= 16'h0000;
		end else if (wr_do) begin
			if (wr_rc80)
				rc80_on <= new_rc80[0];
			if (wr_hrp) begin
				hires_ctrl <= new_hrp[3:0];
				hires_period_count <= new_hrp[31:CPG_HRP_LSB];
			end
			if (wr_fpc)
				frac_ctrl <= new_fpc[3:0];
			if (wr_fpm)
				frac_multiplier <= new_fpm[15:0];
			if (wr_fpd)
				frac_divisor <= new_fpd[15:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < CPG_NUM_GC; i++)
				gc_ctrl[i] <= '0;
		end else if (wr_do & wr_gc_hit) begin
			gc_ctrl[wr_gc_idx] <= {new_gc[31:CPG_GC_DIV_LSB], new_gc[12:CPG_GC_SEL_LSB], new_gc[1:0]};
		end
	end

	// ----------------------------------------------------------------
	// read channel: answer one cycle after the address is taken
	// ----------------------------------------------------------------
	wire         ar_take  = s_axi_arvalid & s_axi_arready;
	wire         rd_gc    = s_axi_araddr[11:4] == CPG_OFS_GC_BASE[11:4];
	wire [1:0]   rd_gi    = s_axi_araddr[3:2];
	wire [31:0]  rd_gcw   = {gc_ctrl[rd_gi].div, 3'h0, gc_ctrl[rd_gi].sel, 6'h00,
		gc_ctrl[rd_gi].divide_on, gc_ctrl[rd_gi].on};
	// version words read-only, variant carries no function
	wire [31:0]  ver_frc  = {8'h00, 4'h0, CPG_VARIANT_NUM, 4'h0, CPG_FRC_VERSION_NUM};
	wire [31:0]  ver_pre  = {8'h00, 4'h0, CPG_VARIANT_NUM, 4'h0, CPG_PRE_VERSION_NUM};
	logic [31:0] rd_word;
	logic        rd_ok;

	// read decode
	always_comb begin
		rd_ok = 1'b1;
		rd_word = CPG_RESET_VALUE;
		if (rd_gc)
			rd_word = rd_gcw;
		else begin
			case (s_axi_araddr)
				CPG_OFS_RC80_CTRL:   rd_word = cur_rc80;
				CPG_OFS_HRP_CTRL:    rd_word = cur_hrp;
				CPG_OFS_FP_CTRL:     rd_word = cur_fpc;
				CPG_OFS_FP_MUL:      rd_word = {16'h0, frac_multiplier};
				CPG_OFS_FP_DIV:      rd_word = {16'h0, frac_divisor};
				CPG_OFS_FRC_VERSION: rd_word = ver_frc;
				CPG_OFS_PRE_VERSION: rd_word = ver_pre;
				default:             rd_ok = 1'b0;
			endcase
		end
	end

	// arready drops for the answer cycle, so one read is in flight at most
	// read handshake
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= CPG_RESET_VALUE;
			s_axi_rresp <= CPG_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_ok ? CPG_RESP_OKAY : CPG_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// high resolution prescaler
	// ----------------------------------------------------------------
	// select is sampled live; software keeps it stable while on
	wire         hrp_tick  = src_tick[hires_ctrl.sel];
	logic [23:0] hrp_cnt;
	// >= rather than ==: a count lowered below the running value acts at once
	// count+1 input periods then toggle; live count compare
	wire         hrp_edge  = hrp_tick & (hrp_cnt >= hires_period_count);
	always_ff @(posedge clk) begin
		if (srst) begin
			hrp_cnt <= 24'h000000;
			hires_prescaled_clock <= 1'b0;
		end else if (!hires_ctrl.on) begin
			// off: finish any high phase, then rest low
			if (!hires_prescaled_clock) begin
				hrp_cnt <= 24'h000000;
			end else if (hrp_tick) begin
				// a cut high phase would be a runt pulse downstream
				hrp_cnt <= hrp_edge ? 24'h000000 : hrp_cnt + 24'h000001;
				if (hrp_edge)
					hires_prescaled_clock <= 1'b0;
			end
		end else if (hrp_tick) begin
			hrp_cnt <= hrp_edge ? 24'h000000 : hrp_cnt + 24'h000001;
			if (hrp_edge)
				hires_prescaled_clock <= ~hires_prescaled_clock;
		end
	end

	// ----------------------------------------------------------------
	// fractional prescaler: accumulator adds mul, wraps at div
	// ----------------------------------------------------------------
	// select held by software while enabled
	wire         fp_tick   = src_tick[frac_ctrl.sel];
	logic [16:0] fp_acc;
	// output pulse rate is in * mul / div
	wire [16:0]  fp_sum    = fp_acc + {1'b0, frac_multiplier};
	wire         fp_wrap   = fp_sum >= {1'b0, frac_divisor};
	// trade-off: pulse train, exact average rate but no even duty cycle
	// mul below div keeps the accumulator bounded
	always_ff @(posedge clk) begin
		if (srst) begin
			fp_acc <= 17'h00000;
			frac_prescaled_clock <= 1'b0;
		end else if (!frac_ctrl.on) begin
			fp_acc <= 17'h00000;
			frac_prescaled_clock <= 1'b0;
		end else begin
			// new mul or div apply at the next tick
			frac_prescaled_clock <= fp_tick & fp_wrap;
			if (fp_tick)
				fp_acc <= fp_wrap ? fp_sum - {1'b0, frac_divisor} : fp_sum;
		end
	end

	// ----------------------------------------------------------------
	// generic clocks and rc80 enable
	// ----------------------------------------------------------------
	// a part with fewer divider bits would tie the upper ones to zero
	// every generic clock here implements all 16 divider bits
	logic [15:0] gc_cnt [CPG_NUM_GC];
	logic [CPG_NUM_GC-1:0] gc_tick;
	logic [CPG_NUM_GC-1:0] gc_wrap;
	always_comb begin
		for (int i = 0; i < CPG_NUM_GC; i++) begin
			// codes at or above the source count have no clock behind them
			// five-bit select, upper codes read as silent
			gc_tick[i] = (gc_ctrl[i].sel < CPG_NUM_SRC) ? src_tick[gc_ctrl[i].sel[2:0]] : 1'b0;
			gc_wrap[i] = gc_cnt[i] >= gc_ctrl[i].div;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rc80_run <= 1'b0;
			gen_clock <= '0;
			for (int i = 0; i < CPG_NUM_GC; i++)
				gc_cnt[i] <= 16'h0000;
		end else begin
			// registered, so the oscillator enable never glitches
			// oscillator runs while enabled, one cycle behind the enable bit
			rc80_run <= rc80_on;
			for (int i = 0; i < CPG_NUM_GC; i++) begin
				if (!gc_ctrl[i].on && !gen_clock[i]) begin
					// disabled and low: stay low, clear divider
					gc_cnt[i] <= 16'h0000;
				end else if (!gc_ctrl[i].divide_on) begin
					// undivided: one pulse per source tick
					gc_cnt[i] <= 16'h0000;
					gen_clock[i] <= gc_tick[i] & gc_ctrl[i].on;
				end else if (gc_tick[i]) begin
					// a disabled divided clock ends its high phase here, so no runt
					// toggle every div+1 ticks: period 2*(div+1)
					gc_cnt[i] <= gc_wrap[i] ? 16'h0000 : gc_cnt[i] + 16'h0001;
					if (gc_wrap[i])
						gen_clock[i] <= ~gen_clock[i];
				end
			end
		end
	end

endmodule

// >>> cpg_top_sva.sv
`timescale 1ns/1ps
module cpg_sva_chk
	import cpg_pkg::*;
(
	input wire logic                   clk,                   // system clock
	input wire logic                   srst,                  // sync reset
	input wire logic [CPG_NUM_SRC-1:0] src_tick,              // source ticks
	input wire logic [11:0]            s_axi_awaddr,          // write address
	input wire logic                   s_axi_awvalid,         // aw valid
	input wire logic                   s_axi_awready,         // aw ready
	input wire logic [31:0]            s_axi_wdata,           // write data
	input wire logic [3:0]             s_axi_wstrb,           // byte enables
	input wire logic                   s_axi_wvalid,          // w valid
	input wire logic                   s_axi_wready,          // w ready
	input wire logic [1:0]             s_axi_bresp,           // write response
	input wire logic                   s_axi_bvalid,          // b valid
	input wire logic                   s_axi_bready,          // b ready
	input wire logic                   s_axi_arvalid,         // ar valid
	input wire logic                   s_axi_arready,         // ar ready
	input wire logic [31:0]            s_axi_rdata,           // read data
	input wire logic                   s_axi_rvalid,          // r valid
	input wire logic                   s_axi_rready,          // r ready
	input wire logic                   rc80_run,              // oscillator enable
	input wire logic                   hires_prescaled_clock, // hires clock
	input wire logic                   frac_prescaled_clock,  // fractional clock
	input wire logic [CPG_NUM_GC-1:0]  gen_clock              // generic clocks
);
	logic       wr_go;
	logic       sh_rc80, sh_hrp, sh_fp, sh_gc_on, sh_gc_dv;
	logic [4:0] sh_gc_sel;
	logic [1:0] age;
	logic [7:0] tick_d;

	// a write is seen only when both channels go in the same edge
	assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];

	// shadow enables; age lets the outputs settle after a write
	always_ff @(posedge clk) begin
		tick_d <= src_tick;
		if (srst) begin
			{sh_rc80, sh_hrp, sh_fp, sh_gc_on, sh_gc_dv, sh_gc_sel} <= '0;
			age <= 2'h0;
		end else if (wr_go) begin
			age <= 2'h0;
			if (s_axi_awaddr == CPG_OFS_RC80_CTRL) sh_rc80 <= s_axi_wdata[0];
			if (s_axi_awaddr == CPG_OFS_HRP_CTRL) sh_hrp <= s_axi_wdata[0];
			if (s_axi_awaddr == CPG_OFS_FP_CTRL) sh_fp <= s_axi_wdata[0];
			if (s_axi_awaddr == CPG_OFS_GC_BASE) {sh_gc_sel, sh_gc_dv, sh_gc_on} <= {s_axi_wdata[12:8], s_axi_wdata[1:0]};
		end else if (age != 2'h3) age <= age + 2'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	AST_RC80_RUN: assert property (age == 2'h3 |-> rc80_run == sh_rc80)
		else $error("rc80 run differs from enable");
	AST_HRP_OFF: assert property (age == 2'h3 && !wr_go && !sh_hrp && !hires_prescaled_clock |=> !hires_prescaled_clock)
		else $error("hires clock moved while off");
	AST_FP_OFF: assert property (age == 2'h3 && !sh_fp |-> !frac_prescaled_clock)
		else $error("frac pulse while off");
	AST_GC_OFF: assert property (age == 2'h3 && !wr_go && !sh_gc_on && !gen_clock[0] |=> !gen_clock[0])
		else $error("generic clock moved while off");
	AST_GC_PASS: assert property (age == 2'h3 && sh_gc_on && !sh_gc_dv && sh_gc_sel < 5'h8 |-> gen_clock[0] == tick_d[sh_gc_sel[2:0]])
		else $error("undivided generic clock not a copy of source");
	AST_RST_QUIET: assert property ($fell(srst) |-> !s_axi_bvalid && !s_axi_rvalid && !rc80_run && gen_clock == '0)
		else $error("outputs not quiet after reset");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) // bus
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) // bus
		else $error("read data dropped early");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // bus
		else $error("read answer late");
	AST_B_LAT: assert property (wr_go |=> s_axi_bvalid) // bus
		else $error("write answer late");

	COV_HIRES: cover property (sh_hrp && $rose(hires_prescaled_clock));
	COV_GC_PASS: cover property (sh_gc_on && !sh_gc_dv && gen_clock[0]);
	COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == CPG_RESP_SLVERR);
endmodule

bind cpg_top cpg_sva_chk cpg_sva_chk_i (.*);

// >>> clock_prescaler_generator_tb_top.sv
`timescale 1ns/1ps
module clock_prescaler_generator_tb_top;
	import cpg_pkg::*;
	logic                   clk, srst, trim_fuse_valid;
	logic [CPG_NUM_SRC-1:0] src_tick = '0;
	logic [9:0]             trim_fuse;
	logic [11:0]            s_axi_awaddr, s_axi_araddr;
	logic [31:0]            s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]             s_axi_wstrb;
	logic [1:0]             s_axi_bresp, s_axi_rresp, rs;
	logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                   s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic                   rc80_run, hires_prescaled_clock, frac_prescaled_clock;
	logic [CPG_NUM_GC-1:0]  gen_clock;
	int                     fail_count, num_checks, h;
	int                     wd = 0;

	cpg_top cpg_top_i (.*);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ticks on every other cycle, so dividers are seen counting ticks, not clocks
	always @(posedge clk) begin
		src_tick <= (src_tick == 8'h00) ? 8'hff : 8'h00;
		wd <= wd + 1;
		if (wd == 20000) begin
			fail_count++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_p, w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// each channel released at the edge that takes it
		do begin
			@(posedge clk);
			if (aw_p && s_axi_awready === 1'b1) begin
				aw_p = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_p && s_axi_wready === 1'b1) begin
				w_p = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (aw_p || w_p);
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		axi_wr(a, d, rs);
		chk(32'(rs), 32'(CPG_RESP_OKAY), "bresp");
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		axi_rd(a, rd, rs);
		chk(32'(rs), 32'(CPG_RESP_OKAY), "rresp");
		chk(rd, exp, "rdata");
	endtask

	function automatic logic probe(input int k);
		return (k == 0) ? hires_prescaled_clock : (k == 5) ? frac_prescaled_clock : gen_clock[k-1];
	endfunction

	// cycles between two changes, after lining up on a first change
	task automatic half(input int k, output int n);
		logic v;
		repeat (2) begin
			v = probe(k);
			n = 0;
			while (probe(k) === v && n < 300) begin
				@(posedge clk);
				n++;
			end
		end
	endtask

	task automatic cnt(input int k, input int c, output int n);
		n = 0;
		repeat (c) begin
			@(posedge clk);
			if (probe(k) === 1'b1) n++;
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 9; i++)
			rdchk((i < 5) ? CPG_OFS_RC80_CTRL + 12'(4 * i) : CPG_OFS_GC_BASE + 12'(4 * (i - 5)), 32'h0);
		wr(CPG_OFS_FRC_VERSION, 32'hffff_ffff);
		rdchk(CPG_OFS_FRC_VERSION, {12'h000, CPG_VARIANT_NUM, 4'h0, CPG_FRC_VERSION_NUM});
		rdchk(CPG_OFS_PRE_VERSION, {12'h000, CPG_VARIANT_NUM, 4'h0, CPG_PRE_VERSION_NUM});
		axi_rd(12'h100, rd, rs);
		chk(32'(rs), 32'(CPG_RESP_SLVERR), "unmapped read");
		axi_wr(12'h100, 32'h1, rs);
		chk(32'(rs), 32'(CPG_RESP_SLVERR), "unmapped write");
	endtask

	task automatic t_rc80();
		trim_fuse <= 10'h2a5;
		trim_fuse_valid <= 1'b1;
		wr(CPG_OFS_RC80_CTRL, 32'hffff_ffff);
		repeat (3) @(posedge clk);
		chk(32'(rc80_run), 32'h1, "rc80 on");
		rdchk(CPG_OFS_RC80_CTRL, 32'h02a5_0081);
		wr(CPG_OFS_RC80_CTRL, 32'h0);
		repeat (3) @(posedge clk);
		chk(32'(rc80_run), 32'h0, "rc80 off");
		rdchk(CPG_OFS_RC80_CTRL, 32'h02a5_0080);
	endtask

	task automatic t_hires();
		wr(CPG_OFS_HRP_CTRL, 32'h0000_0305);
		rdchk(CPG_OFS_HRP_CTRL, 32'h0000_0305);
		half(0, h);
		chk(32'(h), 32'h8, "hires count 3");
		// select kept at 2 while on
		wr(CPG_OFS_HRP_CTRL, 32'h0000_0105);
		half(0, h);
		chk(32'(h), 32'h4, "hires count 1");
		wr(CPG_OFS_HRP_CTRL, 32'h0000_0104);
		repeat (10) @(posedge clk);
		cnt(0, 40, h);
		chk(32'(h), 32'h0, "hires off");
	endtask

	task automatic t_frac();
		wr(CPG_OFS_FP_MUL, 32'hffff_0001);
		rdchk(CPG_OFS_FP_MUL, 32'h0000_0001);
		wr(CPG_OFS_FP_DIV, 32'h0000_0004);
		rdchk(CPG_OFS_FP_DIV, 32'h0000_0004);
		wr(CPG_OFS_FP_CTRL, 32'h0000_0001);
		cnt(5, 80, h);
		chk(32'(h >= 9 && h <= 11), 32'h1, "frac 1/4");
		// select untouched, mul kept below div
		wr(CPG_OFS_FP_DIV, 32'h0000_0002);
		repeat (8) @(posedge clk);
		cnt(5, 80, h);
		chk(32'(h >= 19 && h <= 21), 32'h1, "frac 1/2");
		wr(CPG_OFS_FP_CTRL, 32'h0);
		repeat (4) @(posedge clk);
		cnt(5, 40, h);
		chk(32'(h), 32'h0, "frac off");
	endtask

	task automatic t_gen();
		for (int n = 0; n < CPG_NUM_GC; n++)
			wr(CPG_OFS_GC_BASE + 12'(4 * n), {16'(n), 3'h0, 5'(n), 8'h03});
		rdchk(CPG_OFS_GC_BASE + 12'h8, 32'h0002_0203);
		for (int n = 0; n < CPG_NUM_GC; n++) begin
			half(n + 1, h);
			chk(32'(h), 32'(2 * (n + 1)), "divided generic clock");
		end
		wr(CPG_OFS_GC_BASE, 32'h0005_0101);
		cnt(1, 40, h);
		chk(32'(h), 32'h14, "undivided generic clock");
		wr(CPG_OFS_GC_BASE, 32'h0005_0901);
		repeat (4) @(posedge clk);
		cnt(1, 40, h);
		chk(32'(h), 32'h0, "unused source code");
		wr(CPG_OFS_GC_BASE, 32'h0005_0100);
		repeat (4) @(posedge clk);
		cnt(1, 40, h);
		chk(32'(h), 32'h0, "generic clock off");
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// reset, then the scenarios in turn
	initial begin
		{srst, trim_fuse, trim_fuse_valid, fail_count, num_checks} = '0;
		srst = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset();
		t_rc80();
		t_hires();
		t_frac();
		t_gen();
		summarize();
	end
endmodule
